// ---- src/dvt_pkg.sv ----
package dvt_pkg;
   // Clock rate of clk_sys
   localparam int CLK_MHZ = 10;
   // Horizontal layout in pixel clocks
   localparam int H_SYNC = 8;
   localparam int H_BP   = 48;
   localparam int H_ACT  = 800;
   localparam int H_FP   = 16;
   localparam int H_MIN  = 860;
   // Vertical layout in line periods
   localparam int V_SYNC = 1;
   localparam int V_BP   = 3;
   localparam int V_ACT  = 1280;
   localparam int V_FP   = 5;
   localparam int V_MIN  = 1286;
   // Frame rate window in Hz
   localparam int FR_MIN_HZ = 55;
   localparam int FR_MAX_HZ = 65;
   // Counter widths
   localparam int H_W = 10;
   localparam int V_W = 11;
   localparam int D_W = 8;
   // Derived positions, sized for the counters
   localparam logic [H_W-1:0] H_SYNC_C = H_W'(H_SYNC);
   localparam logic [H_W-1:0] H_ACT_S  = H_W'(H_SYNC + H_BP);
   localparam logic [H_W-1:0] H_ACT_E  = H_W'(H_SYNC + H_BP + H_ACT);
   localparam logic [H_W-1:0] H_TOT_C  = H_W'(H_SYNC + H_BP + H_ACT + H_FP);
   localparam logic [H_W-1:0] H_ACT_C  = H_W'(H_ACT);
   localparam logic [V_W-1:0] V_SYNC_C = V_W'(V_SYNC);
   localparam logic [V_W-1:0] V_ACT_S  = V_W'(V_SYNC + V_BP);
   localparam logic [V_W-1:0] V_ACT_E  = V_W'(V_SYNC + V_BP + V_ACT);
   localparam logic [V_W-1:0] V_TOT_C  = V_W'(V_SYNC + V_BP + V_ACT + V_FP);
   localparam logic [V_W-1:0] V_ACT_C  = V_W'(V_ACT);
   // Packet data types, low six bits of the identifier
   localparam logic [5:0] DT_VSS    = 6'h01;
   localparam logic [5:0] DT_HSS    = 6'h21;
   localparam logic [5:0] DT_RGB888 = 6'h3E;
   // Pixel format
   localparam int PIX_W = 24;
   localparam int COL_W = 8;
   // High-speed bit period window and lane count; the serialiser sits outside this block,
   // so these only bound whatever high-speed stage is attached later
   // bit period
   localparam int UI_MIN_PS = 2000;
   localparam int UI_MAX_PS = 5560;
   localparam int LANES     = 4;
   // Low-power exclusive-OR clock, least pulse and period
   localparam int LP_PULSE_NS  = 50;
   localparam int LP_PER_NS    = 100;
   localparam int LP_PULSE_CYC = (LP_PULSE_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
                                 (LP_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int LP_PER_CYC   = (LP_PER_NS * CLK_MHZ + 999) / 1000;
   localparam int LP_SPACE_CYC = LP_PER_CYC - LP_PULSE_CYC < 1 ? 1 :
                                 LP_PER_CYC - LP_PULSE_CYC;
   // Low-power transmitter states
   typedef enum logic [1:0] {LP_STOP, LP_MARK, LP_SPACE} dvt_lp_type;
endpackage : dvt_pkg

// ---- src/dvt_host.sv ----
`timescale 1ns/1ps
module dvt_host #(
   parameter int PIX_DIV = 2
) (
   input  wire logic                      clk_sys,
   input  wire logic                      rstn,
   input  wire logic [dvt_pkg::PIX_W-1:0] in_data,
   input  wire logic                      in_valid,
   output logic                           in_ready,
   input  wire logic                      underrun_clr,
   output logic                           underrun,
   output logic                           pclk_out,
   output logic                           px_tick,
   output logic                           hsync,
   output logic                           vsync,
   output logic                           de,
   output logic [dvt_pkg::PIX_W-1:0]      pix,
   output logic                           pkt_valid,
   output logic [5:0]                     pkt_type,
   output logic                           frame_start,
   input  wire logic                      lp_start,
   input  wire logic [7:0]                lp_byte,
   output logic                           lp_ready,
   output logic                           lp_dp,
   output logic                           lp_dn
);
   // Divider bounds; frame rate follows clk_sys / PIX_DIV / totals
   // rate from divider
   localparam logic [dvt_pkg::D_W-1:0] DIV_LAST = dvt_pkg::D_W'(PIX_DIV - 1);
   localparam logic [dvt_pkg::D_W-1:0] DIV_HALF = dvt_pkg::D_W'(PIX_DIV / 2);

   logic [dvt_pkg::D_W-1:0] div, next_div;
   logic [dvt_pkg::H_W-1:0] h_cnt, next_h;
   logic [dvt_pkg::V_W-1:0] v_cnt, next_v;
   logic                    next_pclk, step, act;

   // Active region test, shared by timing and buffer logic
   function automatic logic in_active(input logic [dvt_pkg::H_W-1:0] h,
                                      input logic [dvt_pkg::V_W-1:0] v);
      in_active = (h >= dvt_pkg::H_ACT_S) && (h < dvt_pkg::H_ACT_E) &&
                  (v >= dvt_pkg::V_ACT_S) && (v < dvt_pkg::V_ACT_E);
   endfunction : in_active

   // Pixel clock divider and raster counters
   always_comb begin
      step      = (div == DIV_LAST);
      next_div  = step ? '0 : div + 1'b1;
      next_pclk = (next_div < DIV_HALF);
      next_h    = h_cnt;
      next_v    = v_cnt;
      act       = in_active(h_cnt, v_cnt);
      if (step) begin
         if (h_cnt == dvt_pkg::H_TOT_C - 1'b1) begin
            next_h = '0;
            next_v = (v_cnt == dvt_pkg::V_TOT_C - 1'b1) ? '0 : v_cnt + 1'b1;
         end else begin
            next_h = h_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div      <= '0;
         h_cnt    <= '0;
         v_cnt    <= '0;
         pclk_out <= 1'b0;
         px_tick  <= 1'b0;
      end else begin
         div      <= next_div;
         h_cnt    <= next_h;
         v_cnt    <= next_v;
         pclk_out <= next_pclk;
         px_tick  <= step;
      end
   end

   // Two-entry pixel buffer; the raster drains it only in active time
   logic [dvt_pkg::PIX_W-1:0] mem [0:1], next_mem [0:1];
   logic                      wp, rp, next_wp, next_rp, push, pop;
   logic [1:0]                cnt, next_cnt;

   always_comb begin
      push     = in_valid && in_ready;
      pop      = step && act && (cnt != 2'h0);
      next_wp  = push ? ~wp : wp;
      next_rp  = pop ? ~rp : rp;
      next_cnt = cnt + {1'b0, push} - {1'b0, pop};
      for (int i = 0; i < 2; i++) begin
         next_mem[i] = (push && (wp == 1'(i))) ? in_data : mem[i];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wp       <= 1'b0;
         rp       <= 1'b0;
         cnt      <= 2'h0;
         in_ready <= 1'b0;
         mem[0]   <= '0;
         mem[1]   <= '0;
      end else begin
         wp       <= next_wp;
         rp       <= next_rp;
         cnt      <= next_cnt;
         in_ready <= (next_cnt != 2'h2); // Full stalls the source
         mem[0]   <= next_mem[0];
         mem[1]   <= next_mem[1];
      end
   end

   // Sync, enable, pixel and packet type updated once per pixel clock; pkt_valid and frame_start pulse for one clk_sys cycle
   logic                      next_hsync, next_vsync, next_de;
   logic                      next_pkt_valid, next_frame_start, next_underrun;
   logic [dvt_pkg::PIX_W-1:0] next_pix;
   logic [5:0]                next_pkt_type;

   always_comb begin
      next_hsync       = hsync;
      next_vsync       = vsync;
      next_de          = de;
      next_pix         = pix;
      next_pkt_valid   = 1'b0;
      next_pkt_type    = pkt_type;
      next_frame_start = 1'b0;
      // Underrun is sticky; a new one wins over a clear in the same cycle
      next_underrun    = (step && act && (cnt == 2'h0)) || (underrun && !underrun_clr);
      if (step) begin
         next_hsync = (h_cnt < dvt_pkg::H_SYNC_C);
         next_vsync = (v_cnt < dvt_pkg::V_SYNC_C);
         next_de    = act;
         // packed pixel
         // Black goes out on underrun so the line length never slips
         next_pix   = (act && (cnt != 2'h0)) ? mem[rp] : '0;
         if (h_cnt == '0) begin
            next_pkt_valid   = 1'b1;
            next_pkt_type    = (v_cnt == '0) ? dvt_pkg::DT_VSS : dvt_pkg::DT_HSS;
            next_frame_start = (v_cnt == '0);
         end else if (act && (h_cnt == dvt_pkg::H_ACT_S)) begin
            next_pkt_valid = 1'b1;
            next_pkt_type  = dvt_pkg::DT_RGB888;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hsync       <= 1'b0;
         vsync       <= 1'b0;
         de          <= 1'b0;
         pix         <= '0;
         pkt_valid   <= 1'b0;
         pkt_type    <= 6'h00;
         frame_start <= 1'b0;
         underrun    <= 1'b0;
      end else begin
         hsync       <= next_hsync;
         vsync       <= next_vsync;
         de          <= next_de;
         pix         <= next_pix;
         pkt_valid   <= next_pkt_valid;
         pkt_type    <= next_pkt_type;
         frame_start <= next_frame_start;
         underrun    <= next_underrun;
      end
   end

   // Low-power byte sender, spaced one-hot, LSB first
   dvt_pkg::dvt_lp_type lp_st, next_lp_st;
   logic [7:0]          sh, next_sh;
   logic [2:0]          bit_n, next_bit_n;
   logic [3:0]          tmr, next_tmr;
   logic                next_dp, next_dn;

   always_comb begin
      next_lp_st = lp_st;
      next_sh    = sh;
      next_bit_n = bit_n;
      next_tmr   = (tmr == 4'h0) ? 4'h0 : tmr - 1'b1;
      case (lp_st)
         dvt_pkg::LP_STOP: begin
            if (lp_start) begin
               next_lp_st = dvt_pkg::LP_MARK;
               next_sh    = lp_byte;
               next_bit_n = 3'h0;
               next_tmr   = 4'(dvt_pkg::LP_PULSE_CYC - 1);
            end
         end
         dvt_pkg::LP_MARK: begin
            if (tmr == 4'h0) begin
               next_lp_st = dvt_pkg::LP_SPACE;
               next_tmr   = 4'(dvt_pkg::LP_SPACE_CYC - 1);
            end
         end
         dvt_pkg::LP_SPACE: begin
            if (tmr == 4'h0) begin
               next_sh    = {1'b0, sh[7:1]};
               next_bit_n = bit_n + 1'b1;
               next_lp_st = (bit_n == 3'h7) ? dvt_pkg::LP_STOP : dvt_pkg::LP_MARK;
               next_tmr   = 4'(dvt_pkg::LP_PULSE_CYC - 1);
            end
         end
         default: begin
            next_lp_st = dvt_pkg::LP_STOP;
         end
      endcase
      // Stop state drives both lines high, space both low
      next_dp = (next_lp_st == dvt_pkg::LP_STOP) ||
                ((next_lp_st == dvt_pkg::LP_MARK) && next_sh[0]);
      next_dn = (next_lp_st == dvt_pkg::LP_STOP) ||
                ((next_lp_st == dvt_pkg::LP_MARK) && !next_sh[0]);
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lp_st    <= dvt_pkg::LP_STOP;
         sh       <= 8'h00;
         bit_n    <= 3'h0;
         tmr      <= 4'h0;
         lp_ready <= 1'b1;
         lp_dp    <= 1'b1;
         lp_dn    <= 1'b1;
      end else begin
         lp_st    <= next_lp_st;
         sh       <= next_sh;
         bit_n    <= next_bit_n;
         tmr      <= next_tmr;
         lp_ready <= (next_lp_st == dvt_pkg::LP_STOP);
         lp_dp    <= next_dp;
         lp_dn    <= next_dn;
      end
   end

   // Helper counters for the checks below
   logic [dvt_pkg::H_W-1:0] hs_n, de_n, ln_n;
   logic [dvt_pkg::V_W-1:0] vl_n, al_n;
   logic [3:0]              xw_n, xp_n;
   logic                    lp_x, lp_x_q;

   assign lp_x = lp_dp ^ lp_dn;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hs_n   <= '0;
         de_n   <= '0;
         ln_n   <= '0;
         vl_n   <= '0;
         al_n   <= '0;
         xw_n   <= 4'h0;
         xp_n   <= 4'h0;
         lp_x_q <= 1'b0;
      end else begin
         lp_x_q <= lp_x;
         xw_n   <= lp_x ? xw_n + 1'b1 : 4'h0;
         xp_n   <= (lp_x && !lp_x_q) ? 4'h1 : ((xp_n == 4'hF) ? xp_n : xp_n + 1'b1);
         if (px_tick) begin
            hs_n <= hsync ? hs_n + 1'b1 : '0;
            de_n <= de ? de_n + 1'b1 : '0;
            ln_n <= (hsync && hs_n == '0) ? 10'h001 : ln_n + 1'b1;
            if (hsync && hs_n == '0) begin
               vl_n <= vsync ? vl_n + 1'b1 : '0;
            end
            if (vsync && !$past(vsync)) begin
               al_n <= '0;
            end else if (!de && de_n != '0) begin
               al_n <= al_n + 1'b1;
            end
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   property p_line_px;
      $fell(de) |-> de_n == dvt_pkg::H_ACT_C;
   endproperty
   a_line_px: assert property (p_line_px) else $error("active pixels per line wrong");

   property p_hsw;
      $fell(hsync) |-> hs_n == dvt_pkg::H_SYNC_C;
   endproperty
   a_hsw: assert property (p_hsw) else $error("hsync width wrong");

   property p_line_tot;
      ($rose(hsync) && ln_n != '0) |-> ln_n == dvt_pkg::H_TOT_C && ln_n >= 10'(dvt_pkg::H_MIN);
   endproperty
   a_line_tot: assert property (p_line_tot) else $error("line period wrong");

   property p_vsw;
      $fell(vsync) |-> vl_n == dvt_pkg::V_SYNC_C;
   endproperty
   a_vsw: assert property (p_vsw) else $error("vsync width wrong");

   property p_frame_lines;
      ($rose(vsync) && al_n != '0) |-> al_n == dvt_pkg::V_ACT_C;
   endproperty
   a_frame_lines: assert property (p_frame_lines) else $error("active lines wrong");

   property p_pix_pkt;
      $rose(de) |-> pkt_valid && pkt_type == dvt_pkg::DT_RGB888;
   endproperty
   a_pix_pkt: assert property (p_pix_pkt) else $error("pixel packet type wrong");

   property p_vs_pkt;
      $rose(vsync) |-> pkt_valid && pkt_type == dvt_pkg::DT_VSS && frame_start;
   endproperty
   a_vs_pkt: assert property (p_vs_pkt) else $error("vsync packet wrong");

   property p_hs_pkt;
      ($rose(hsync) && !vsync) |-> pkt_valid && pkt_type == dvt_pkg::DT_HSS;
   endproperty
   a_hs_pkt: assert property (p_hs_pkt) else $error("hsync packet wrong");

   property p_lp_pulse;
      $fell(lp_x) |-> xw_n >= 4'(dvt_pkg::LP_PULSE_CYC);
   endproperty
   a_lp_pulse: assert property (p_lp_pulse) else $error("lp pulse too short");

   property p_lp_per;
      ($rose(lp_x) && xp_n != 4'h0) |-> xp_n >= 4'(dvt_pkg::LP_PER_CYC);
   endproperty
   a_lp_per: assert property (p_lp_per) else $error("lp period too short");

   property p_lp_byte;
      (lp_ready && lp_start) |=> !lp_ready [*8];
   endproperty
   a_lp_byte: assert property (p_lp_byte) else $error("lp byte ended early");

   c_frame: cover property (frame_start);
   c_underrun: cover property ($rose(underrun));
   c_stall: cover property (in_valid && !in_ready);
   c_lp_done: cover property ($rose(lp_ready));
endmodule : dvt_host

// ---- verification/dvt_panel.sv ----
`timescale 1ns/1ps
// Panel side: counts shown pixels per line and decodes low-power bytes
module dvt_panel (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        px_tick,
   input  wire logic        de,
   input  wire logic        lp_dp,
   input  wire logic        lp_dn,
   output logic [15:0]      line_px,
   output logic             line_stb,
   output logic [7:0]       rx_byte,
   output logic             rx_stb,
   output logic [7:0]       lp_bad
);
   localparam int NS = 1000 / dvt_pkg::CLK_MHZ;
   logic [1:0] lvl;
   logic [7:0] sh;
   logic       de_q;
   int         cnt;
   int         wid;
   int         per;
   int         nb;
   // video and low-power
   // No frame store: pixels are counted as they pass, never kept
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lvl <= 2'h3;
         sh <= 8'h00;
         de_q <= 1'b0;
         cnt <= 0;
         wid <= 0;
         per <= 0;
         nb <= 0;
         line_px <= 16'h0;
         line_stb <= 1'b0;
         rx_byte <= 8'h00;
         rx_stb <= 1'b0;
         lp_bad <= 8'h00;
      end else begin
         line_stb <= 1'b0;
         rx_stb <= 1'b0;
         lvl <= {lp_dp, lp_dn};
         if (px_tick) begin
            de_q <= de;
            cnt <= de ? cnt + 1 : 0;
            if (de_q && !de) begin
               line_px <= 16'(cnt);
               line_stb <= 1'b1;
            end
         end
         if ({lp_dp, lp_dn} == lvl) begin
            wid <= wid + 1;
            per <= per + 1;
         end else begin
            wid <= 1;
            per <= (lp_dp ^ lp_dn) ? 1 : per + 1;
            if ((lvl[1] ^ lvl[0]) && wid * NS < dvt_pkg::LP_PULSE_NS) lp_bad <= lp_bad + 8'h01;
            // mark period
            // First mark after stop has no period before it
            if ((lp_dp ^ lp_dn) && lvl != 2'h3 && per * NS < dvt_pkg::LP_PER_NS)
               lp_bad <= lp_bad + 8'h01;
            if (lp_dp ^ lp_dn) begin
               sh <= {lp_dp, sh[7:1]};
               nb <= nb + 1;
            end
            if (lp_dp && lp_dn) begin
               rx_byte <= sh;
               rx_stb <= nb == 8;
               nb <= 0;
            end
         end
      end
   end
endmodule : dvt_panel

// ---- verification/test_dsi_video_timing_800x1280.sv ----
`timescale 1ns/1ps
// Video host against a panel model; raster predicted from integer counters
module test_dsi_video_timing_800x1280;
   localparam int DIV   = 4;
   localparam int LIMIT = 30000;
   logic                      clk_sys = 1'b0;
   logic                      rstn = 1'b0;
   logic [dvt_pkg::PIX_W-1:0] in_data = 24'h0;
   logic                      in_valid = 1'b0;
   logic                      underrun_clr = 1'b0;
   logic                      lp_start = 1'b0;
   logic [7:0]                lp_byte = 8'h00;
   logic                      in_ready, underrun, pclk_out, px_tick, hsync, vsync, de;
   logic                      pkt_valid, frame_start, lp_ready, lp_dp, lp_dn;
   logic                      line_stb, rx_stb, src_on = 1'b1, act;
   logic [dvt_pkg::PIX_W-1:0] pix;
   logic [5:0]                pkt_type;
   logic [15:0]               line_px;
   logic [7:0]                rx_byte, lp_bad;
   logic [23:0]               fifo_q[$];
   logic [7:0]                byte_q[$];
   int                        fails = 0, n_checks = 0, cyc = 0;
   int                        eh = 0, ev = 0, gap = 0, ones = 0, seen = 0;

   always #50 clk_sys = ~clk_sys;

   dvt_host #(.PIX_DIV(DIV)) dut (
      .clk_sys      (clk_sys),
      .rstn         (rstn),
      .in_data      (in_data),
      .in_valid     (in_valid),
      .in_ready     (in_ready),
      .underrun_clr (underrun_clr),
      .underrun     (underrun),
      .pclk_out     (pclk_out),
      .px_tick      (px_tick),
      .hsync        (hsync),
      .vsync        (vsync),
      .de           (de),
      .pix          (pix),
      .pkt_valid    (pkt_valid),
      .pkt_type     (pkt_type),
      .frame_start  (frame_start),
      .lp_start     (lp_start),
      .lp_byte      (lp_byte),
      .lp_ready     (lp_ready),
      .lp_dp        (lp_dp),
      .lp_dn        (lp_dn)
   );

   dvt_panel panel (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .px_tick  (px_tick),
      .de       (de),
      .lp_dp    (lp_dp),
      .lp_dn    (lp_dn),
      .line_px  (line_px),
      .line_stb (line_stb),
      .rx_byte  (rx_byte),
      .rx_stb   (rx_stb),
      .lp_bad   (lp_bad)
   );

   task automatic chk_bit(string name, logic e, logic g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %b seen %b", name, e, g);
      end
   endtask : chk_bit

   task automatic chk_val(string name, logic [23:0] e, logic [23:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, e, g);
      end
   endtask : chk_val

   task automatic chk_cnt(string name, int e, int g);
      n_checks++;
      if (g != e) begin
         fails++;
         $display("[FAIL] %s expected %0d seen %0d", name, e, g);
      end
   endtask : chk_cnt

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   // Waits for a raster position; the timeout catches a stuck raster
   task automatic wait_at(int v, int h);
      while (!(ev == v && eh == h)) @(posedge clk_sys);
   endtask : wait_at

   // One byte, with a refused start thrown in while busy
   task automatic send_lp(logic [7:0] b);
      int n;
      n = 0;
      byte_q.push_back(b);
      lp_byte <= b;
      lp_start <= 1'b1;
      @(posedge clk_sys);
      lp_start <= 1'b0;
      repeat (4) @(posedge clk_sys);
      lp_byte <= ~b;
      lp_start <= 1'b1;
      @(posedge clk_sys);
      lp_start <= 1'b0;
      n = 5;
      while (lp_ready !== 1'b1 && n < 40) begin
         @(posedge clk_sys);
         n++;
      end
      // Edges from the taking edge to the one that sees the sender idle again
      chk_cnt("lp_busy_cycles", 1 + 8 * (dvt_pkg::LP_PULSE_CYC + dvt_pkg::LP_SPACE_CYC), n);
   endtask : send_lp

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fails++;
         test_done();
      end
   end

   // Source keeps the buffer topped up unless a scenario starves it
   always @(posedge clk_sys) begin
      if (rstn) begin
         if (in_valid && in_ready) begin
            fifo_q.push_back(in_data);
            in_data <= 24'($urandom);
         end
         in_valid <= src_on;
      end
   end

   // Raster model: one step per pixel tick
   always @(posedge clk_sys) begin
      act = ev >= 4 && ev < 1284 && eh >= 56 && eh < 856;
      if (rstn && px_tick === 1'b1) begin
         chk_bit("hsync", eh < 8, hsync);
         chk_bit("vsync", ev < 1, vsync);
         chk_bit("de", act, de);
         chk_bit("frame_start", eh == 0 && ev == 0, frame_start);
         chk_bit("pkt_valid", eh == 0 || (act && eh == 56), pkt_valid);
         if (eh == 0) chk_val("pkt_type", ev == 0 ? 24'h1 : 24'h21, 24'(pkt_type));
         if (act && eh == 56) chk_val("pkt_type", 24'h3E, 24'(pkt_type));
         if (act) chk_val("pix", fifo_q.size() > 0 ? fifo_q.pop_front() : 24'h0, pix);
         if (seen > 0) chk_cnt("tick_gap", DIV, gap);
         if (seen > 0) chk_cnt("pclk_high", DIV / 2, ones);
         gap = 1;
         ones = int'(pclk_out === 1'b1);
         seen = 1;
         eh = (eh == 871) ? 0 : eh + 1;
         if (eh == 0) ev = (ev == 1288) ? 0 : ev + 1;
      end else if (rstn) begin
         chk_bit("pkt_valid_idle", 1'b0, pkt_valid);
         gap++;
         ones += int'(pclk_out === 1'b1);
      end
      if (line_stb === 1'b1) chk_val("line_px", 24'h320, 24'(line_px));
      if (rx_stb === 1'b1) chk_val("lp_byte", 24'(byte_q.pop_front()), 24'(rx_byte));
   end

   initial begin
      void'($urandom(32'hddfd6989));
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk_bit("in_ready_full", 1'b0, in_ready);
      // bytes back to back, edge patterns first
      for (int k = 0; k < 4; k++) send_lp(k == 0 ? 8'hA5 : k == 1 ? 8'h00 : k == 2 ? 8'hFF : 8'($urandom));
      // a starved line shows black and flags it
      wait_at(5, 1);
      chk_bit("underrun_before", 1'b0, underrun);
      src_on <= 1'b0;
      wait_at(5, 858);
      src_on <= 1'b1;
      chk_bit("underrun_set", 1'b1, underrun);
      underrun_clr <= 1'b1;
      @(posedge clk_sys);
      underrun_clr <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk_bit("underrun_clr", 1'b0, underrun);
      wait_at(7, 1);
      chk_val("lp_bad", 24'h0, 24'(lp_bad));
      chk_cnt("lp_left", 0, byte_q.size());
      test_done();
   end
endmodule : test_dsi_video_timing_800x1280
